// ### include/gct_pkg.sv
/*
  Shared constants of the general counter/timer block: register map,
  control field positions, clock source codes, modes and prescale counts.
  Assumes a single 40 MHz system clock and an 8-bit register address.
*/
package gct_pkg;
  localparam int unsigned NTMR = 6;
  localparam int unsigned DW = 32;
  localparam int unsigned AW = 8;
  localparam int unsigned NSYNC = 10;

  // Register map: timer n owns four words at n*4; the field is addr[1:0].
  localparam logic [1:0] FLD_CTRL = 2'h0;
  localparam logic [1:0] FLD_RELOAD = 2'h1;
  localparam logic [1:0] FLD_COUNT = 2'h2;
  localparam logic [1:0] FLD_CAPTURE = 2'h3;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_MASK = 8'h21;

  // Control word fields.
  localparam int unsigned CTRL_W = 10;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_CLK_LO = 1;
  localparam int unsigned CTRL_MODE_LO = 4;
  localparam int unsigned CTRL_CAPEN = 6;
  localparam int unsigned CTRL_CAPSRC_LO = 7;
  localparam int unsigned CTRL_CHAIN = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;

  // Clock source codes, also the index into the tick vector.
  localparam logic [2:0] CLK_SYS = 3'h0;
  localparam logic [2:0] CLK_DIV12 = 3'h1;
  localparam logic [2:0] CLK_DIV4 = 3'h2;
  localparam logic [2:0] CLK_DIV48 = 3'h3;
  localparam logic [2:0] CLK_EXT8 = 3'h4;
  localparam logic [2:0] CLK_PIN = 3'h5;
  localparam logic [2:0] CLK_LFO8 = 3'h6;

  // Classic timer modes and the auto-reload timer modes.
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT_AR = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam logic [1:0] MODE_AR16 = 2'h0;
  localparam logic [1:0] MODE_AR_SPLIT = 2'h1;

  // Capture source codes.
  localparam logic [1:0] CAP_PIN = 2'h0;
  localparam logic [1:0] CAP_LFO = 2'h1;
  localparam logic [1:0] CAP_CMP0 = 2'h2;
  localparam logic [1:0] CAP_CLU = 2'h3;

  // Synchroniser lanes: timer pins, then the shared inputs.
  localparam int unsigned SY_EXT = 6;
  localparam int unsigned SY_LFO = 7;
  localparam int unsigned SY_CMP0 = 8;
  localparam int unsigned SY_CLU = 9;

  // Prescale divisors (counter terminal values are divisor minus one).
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  // Status and mask layout: overflow, high-byte overflow, capture.
  localparam int unsigned ST_W = 18;
  localparam int unsigned ST_OVF = 0;
  localparam int unsigned ST_OVH = 6;
  localparam int unsigned ST_CAP = 12;
endpackage

// ### core/gct_timers.sv
/*
  Six 16-bit counter/timers with a register port and one interrupt line.
  Assumes pins and the oscillator/comparator/logic inputs are asynchronous
  to mclk and much slower than it; the power mode input is on mclk.
*/
// Strobed register access and the register addresses were decided locally.
// Functional notes
// - Six timers: two classic, four auto-reload.
// - Timers measure, count events, raise interrupts.
// - Timers 0/1 clock: sys, /12, /4, /48, ext/8, pin.
// - Timers 0/1: 8-bit AR, 13, 16, dual 8.
// - Dual 8-bit split only on timer 0.
// - Timers 2-5 clock: sys, /12, ext/8.
// - Timers 3/4 also low-frequency /8, runs in low power.
// - Timer 4 overflow wakes the device.
// - Timer 4 may chain after timer 3.
// - Timers 2-5: 16-bit or dual 8-bit auto-reload.
// - Timers 2-5 capture on pin, oscillator, comparator, logic.
`timescale 1ns/1ps
module gct_timers (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [gct_pkg::AW-1:0] addr,
  input wire logic [gct_pkg::DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [gct_pkg::DW-1:0] rdata,
  input wire logic [gct_pkg::NTMR-1:0] tmr_pin,
  input wire logic ext_clk,
  input wire logic low_freq_oscillator,
  input wire logic cmp0_out,
  input wire logic clu_out,
  input wire logic low_power,
  output logic irq,
  output logic wake
);
  import gct_pkg::*;

  typedef struct packed {
    logic [NSYNC-1:0] sy1;
    logic [NSYNC-1:0] sy2;
    logic [NSYNC-1:0] sy3;
    logic [5:0] p48;
    logic [3:0] p12;
    logic [1:0] p4;
    logic [2:0] ediv;
    logic [2:0] ldiv;
    logic [NTMR-1:0][CTRL_W-1:0] ctrl;
    logic [NTMR-1:0][15:0] rld;
    logic [NTMR-1:0][15:0] cnt;
    logic [NTMR-1:0][15:0] cap;
    logic [ST_W-1:0] stat;
    logic [ST_W-1:0] mask;
    logic [DW-1:0] rdata;
    logic irq;
    logic wake;
  } gct_state_t;

  gct_state_t st;
  gct_state_t next_st;

  // Legal clock sources differ per timer; an illegal choice never ticks.
  function automatic logic src_ok(input int unsigned n, input logic [2:0] sel);
    logic ok;
    ok = 1'b0;
    if (n < 2) begin
      ok = (sel <= CLK_PIN);
    end else if (sel == CLK_SYS || sel == CLK_DIV12 || sel == CLK_EXT8) begin
      ok = 1'b1;
    end else if ((n == 3 || n == 4) && sel == CLK_LFO8) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // Decodes the timer index from an address; valid only below the globals.
  function automatic logic tmr_hit(input logic [AW-1:0] a, input int unsigned n);
    return a[AW-1:2] == n[AW-3:0];
  endfunction

  logic [NSYNC-1:0] edges;
  logic [7:0] ticks;
  logic [ST_W-1:0] ev;
  logic t3_ovf;
  logic t4_ovf;

  always_comb begin
    logic [2:0] sel;
    logic [1:0] mode;
    logic tick;
    logic ovf;
    logic ovh;
    logic [12:0] v13;
    logic capev;
    next_st = st;
    sel = 3'h0;
    mode = 2'h0;
    tick = 1'b0;
    ovf = 1'b0;
    ovh = 1'b0;
    v13 = 13'h0000;
    capev = 1'b0;
    ev = '0;
    t3_ovf = 1'b0;
    t4_ovf = 1'b0;

    next_st.sy1 = {clu_out, cmp0_out, low_freq_oscillator, ext_clk, tmr_pin};
    next_st.sy2 = st.sy1;
    next_st.sy3 = st.sy2;
    edges = st.sy2 & ~st.sy3;

    // Prescalers: free-running so every timer sees the same phase.
    next_st.p48 = (st.p48 == DIV48_LAST) ? 6'h00 : st.p48 + 6'h01;
    next_st.p12 = (st.p12 == DIV12_LAST) ? 4'h0 : st.p12 + 4'h1;
    next_st.p4 = st.p4 + 2'h1;
    if (edges[SY_EXT]) begin
      next_st.ediv = st.ediv + 3'h1;
    end
    if (edges[SY_LFO]) begin
      next_st.ldiv = st.ldiv + 3'h1;
    end
    ticks = 8'h00;
    ticks[CLK_SYS] = 1'b1;
    ticks[CLK_DIV12] = (st.p12 == DIV12_LAST);
    ticks[CLK_DIV4] = (st.p4 == DIV4_LAST);
    ticks[CLK_DIV48] = (st.p48 == DIV48_LAST);
    ticks[CLK_EXT8] = edges[SY_EXT] && (st.ediv == DIV8_LAST);
    ticks[CLK_LFO8] = edges[SY_LFO] && (st.ldiv == DIV8_LAST);

    for (int unsigned n = 0; n < NTMR; n++) begin
      sel = st.ctrl[n][CTRL_CLK_LO +: 3];
      mode = st.ctrl[n][CTRL_MODE_LO +: 2];
      ticks[CLK_PIN] = edges[n];
      tick = st.ctrl[n][CTRL_RUN] && src_ok(n, sel) && ticks[sel];
      // In low power only the low-frequency clocked timers keep going.
      if (low_power && !((n == 3 || n == 4) && sel == CLK_LFO8)) begin
        tick = 1'b0;
      end
      if (n == 4 && st.ctrl[n][CTRL_CHAIN]) begin
        tick = st.ctrl[n][CTRL_RUN] && t3_ovf;
      end
      ovf = 1'b0;
      ovh = 1'b0;
      if (tick) begin
        if (n < 2) begin
          case (mode)
            MODE_13BIT: begin
              v13 = {st.cnt[n][15:8], st.cnt[n][4:0]};
              ovf = &v13;
              v13 = v13 + 13'h0001;
              next_st.cnt[n][15:8] = v13[12:5];
              next_st.cnt[n][4:0] = v13[4:0];
            end
            MODE_16BIT: begin
              ovf = &st.cnt[n];
              next_st.cnt[n] = st.cnt[n] + 16'h0001;
            end
            MODE_8BIT_AR: begin
              ovf = &st.cnt[n][7:0];
              next_st.cnt[n][7:0] = ovf ? st.rld[n][7:0] : st.cnt[n][7:0] + 8'h01;
            end
            default: begin
              // Timer 1 holds still in split mode; the classic part did too.
              if (n == 0) begin
                ovf = &st.cnt[n][7:0];
                ovh = &st.cnt[n][15:8];
                next_st.cnt[n][7:0] = st.cnt[n][7:0] + 8'h01;
                next_st.cnt[n][15:8] = st.cnt[n][15:8] + 8'h01;
              end
            end
          endcase
        end else if (mode == MODE_AR_SPLIT) begin
          ovf = &st.cnt[n][7:0];
          ovh = &st.cnt[n][15:8];
          next_st.cnt[n][7:0] = ovf ? st.rld[n][7:0] : st.cnt[n][7:0] + 8'h01;
          next_st.cnt[n][15:8] = ovh ? st.rld[n][15:8] : st.cnt[n][15:8] + 8'h01;
        end else begin
          ovf = &st.cnt[n];
          next_st.cnt[n] = ovf ? st.rld[n] : st.cnt[n] + 16'h0001;
        end
      end
      if (n == 3) begin
        t3_ovf = ovf;
      end
      if (n == 4) begin
        t4_ovf = ovf;
      end
      ev[ST_OVF + n] = ovf;
      ev[ST_OVH + n] = ovh;

      if (n >= 2) begin
        case (st.ctrl[n][CTRL_CAPSRC_LO +: 2])
          CAP_PIN: capev = edges[n];
          CAP_LFO: capev = edges[SY_LFO];
          CAP_CMP0: capev = edges[SY_CMP0];
          default: capev = edges[SY_CLU];
        endcase
        if (st.ctrl[n][CTRL_CAPEN] && capev) begin
          next_st.cap[n] = st.cnt[n];
          ev[ST_CAP + n] = 1'b1;
        end
      end
    end

    // Register writes; a write to the count wins over the same-cycle tick.
    if (wr) begin
      if (addr == REG_MASK) begin
        next_st.mask = wdata[ST_W-1:0];
      end else begin
        for (int unsigned n = 0; n < NTMR; n++) begin
          if (tmr_hit(addr, n)) begin
            if (addr[1:0] == FLD_CTRL) begin
              next_st.ctrl[n] = wdata[CTRL_W-1:0];
            end else if (addr[1:0] == FLD_RELOAD) begin
              next_st.rld[n] = wdata[15:0];
            end else if (addr[1:0] == FLD_COUNT) begin
              next_st.cnt[n] = wdata[15:0];
            end
          end
        end
      end
    end

    // Reads: data valid the cycle after the strobe, zero elsewhere.
    next_st.rdata = '0;
    if (rd) begin
      if (addr == REG_STATUS) begin
        next_st.rdata = {{(DW-ST_W){1'b0}}, st.stat};
      end else if (addr == REG_MASK) begin
        next_st.rdata = {{(DW-ST_W){1'b0}}, st.mask};
      end else begin
        for (int unsigned n = 0; n < NTMR; n++) begin
          if (tmr_hit(addr, n)) begin
            if (addr[1:0] == FLD_CTRL) begin
              next_st.rdata = {{(DW-CTRL_W){1'b0}}, st.ctrl[n]};
            end else if (addr[1:0] == FLD_RELOAD) begin
              next_st.rdata = {16'h0000, st.rld[n]};
            end else if (addr[1:0] == FLD_COUNT) begin
              next_st.rdata = {16'h0000, st.cnt[n]};
            end else begin
              next_st.rdata = {16'h0000, st.cap[n]};
            end
          end
        end
      end
    end

    // Reading status clears only the bits it returned; a new event wins.
    next_st.stat = st.stat;
    if (rd && addr == REG_STATUS) begin
      next_st.stat = '0;
    end
    next_st.stat = next_st.stat | ev;
    next_st.irq = |(next_st.stat & next_st.mask);
    next_st.wake = low_power && t4_ovf;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      for (int unsigned n = 0; n < NTMR; n++) begin
        st.ctrl[n] <= CTRL_RESET;
        st.rld[n] <= RELOAD_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq = st.irq;
  assign wake = st.wake;
endmodule

// ### bench/gct_timers_assertions.sv
/*
  Port checker for gct_timers.
  Assumes binding to every gct_timers instance; watches ports only.
*/
`timescale 1ns/1ps
module gct_timers_chk import gct_pkg::*; (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [gct_pkg::AW-1:0] addr,
  input wire logic [gct_pkg::DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [gct_pkg::DW-1:0] rdata,
  input wire logic low_power,
  input wire logic irq,
  input wire logic wake
);
  logic [ST_W-1:0] msk;
  logic [AW-1:0] wa;
  logic [15:0] wd;
  // Shadows of the last write let reads be judged without seeing the body.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      msk <= '0;
      wa <= 8'hff;
      wd <= '0;
    end else if (wr) begin
      wa <= addr;
      wd <= wdata[15:0];
      if (addr == REG_MASK) msk <= wdata[ST_W-1:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside read answer");
  a_unmapped_zero: assert property ((rd && (addr > REG_MASK || addr inside {[8'h18:8'h1f]}))
    |=> rdata == '0) else $error("unmapped read not zero");
  a_wake_pulse: assert property (wake |=> !wake) else $error("wake too long");
  a_wake_lowpow: assert property (wake |-> $past(low_power))
    else $error("wake outside low power");
  a_irq_masked: assert property (msk == '0 && $past(msk) == '0 |-> !irq)
    else $error("irq while fully masked");
  a_mask_read: assert property (rd && addr == REG_MASK |=> rdata == 32'(msk))
    else $error("mask readback wrong");
  a_reload_back: assert property ((rd && addr == wa && addr < 8'h18 && addr[1:0] == FLD_RELOAD)
    |=> rdata == 32'(wd)) else $error("reload readback wrong");
  a_irq_fall: assert property ($fell(irq) |-> $past(rd && addr == REG_STATUS)
    || $past(wr && addr == REG_MASK) || $past(rd && addr == REG_STATUS, 2)
    || $past(wr && addr == REG_MASK, 2)) else $error("irq fell unprompted");
endmodule
bind gct_timers gct_timers_chk chk_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .low_power(low_power), .irq(irq), .wake(wake));

// ### bench/general_counter_timers_tb_top.sv
/*
  Register-level scenarios for gct_timers.
  Assumes the checker is bound from its own file; the bench drives every input.
*/
`timescale 1ns/1ps
module general_counter_timers_tb_top;
  import gct_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic low_power = 1'b0;
  logic [9:0] ins = '0;
  logic [DW-1:0] rdata;
  logic irq;
  logic wake;
  logic woke = 1'b0;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  always #12.5 mclk = ~mclk;
  gct_timers dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tmr_pin(ins[5:0]), .ext_clk(ins[6]), .low_freq_oscillator(ins[7]),
    .cmp0_out(ins[8]), .clu_out(ins[9]), .low_power(low_power), .irq(irq), .wake(wake));
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) woke <= 1'b1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [DW-1:0] exp, logic [DW-1:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(string nm, int lo, int hi, logic [DW-1:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %h", nm, lo, hi, got);
    end
  endtask
  task automatic wreg(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(string nm, logic [AW-1:0] a, logic [DW-1:0] exp);
    logic [DW-1:0] v;
    rreg(a, v);
    chk(nm, exp, v);
  endtask
  task automatic cycles(int n);
    repeat (n) @(posedge mclk);
  endtask
  // Pulses stay high three cycles so the two-flop synchroniser never misses one.
  task automatic tog(int i, int n);
    repeat (n) begin
      @(posedge mclk);
      ins[i] <= 1'b1;
      cycles(3);
      ins[i] <= 1'b0;
      cycles(3);
    end
  endtask
  function automatic logic [DW-1:0] cw(int clk, logic [1:0] md, int ex);
    return 32'(1 + 2 * clk + 16 * md + ex);
  endfunction
  task automatic t_map();
    rchk("ctrl0", 8'h00, 32'h0);
    rchk("rl5", 8'h15, 32'h0);
    wreg(8'h15, 32'habcd);
    rchk("rl5w", 8'h15, 32'habcd);
    wreg(8'h18, 32'h1);
    rchk("t6", 8'h18, 32'h0);
    wreg(REG_STATUS, 32'h3ffff);
    rchk("stat", REG_STATUS, 32'h0);
    rchk("mask", REG_MASK, 32'h0);
  endtask
  task automatic t_pre();
    logic [DW-1:0] v;
    int dv[4] = '{1, 12, 4, 48};
    for (int c = 0; c < 4; c++) begin
      wreg(8'h02, 32'h0);
      wreg(8'h00, cw(c, MODE_16BIT, 0));
      cycles(480);
      wreg(8'h00, 32'h0);
      rreg(8'h02, v);
      chk_rng("t0_div", 480 / dv[c] - 1, 480 / dv[c] + 3, v);
    end
  endtask
  task automatic t_t1();
    wreg(8'h04, cw(CLK_EXT8, MODE_16BIT, 0));
    tog(SY_EXT, 16);
    rchk("t1_ext", 8'h06, 32'h2);
    wreg(8'h06, 32'h0);
    wreg(8'h04, cw(CLK_PIN, MODE_16BIT, 0));
    tog(1, 5);
    rchk("t1_pin", 8'h06, 32'h5);
    wreg(8'h04, cw(CLK_SYS, MODE_SPLIT, 0));
    cycles(20);
    rchk("t1_split", 8'h06, 32'h5);
    wreg(8'h04, 32'h0);
  endtask
  task automatic t_ovf(logic [DW-1:0] m, logic ei);
    logic [DW-1:0] v;
    wreg(REG_MASK, m);
    wreg(8'h09, 32'h1200);
    wreg(8'h0a, 32'hfffd);
    wreg(8'h08, cw(CLK_SYS, MODE_AR16, 0));
    cycles(8);
    wreg(8'h08, 32'h0);
    #1;
    chk("irq", ei, irq);
    rreg(8'h0a, v);
    chk("t2_hi", 32'h12, v >> 8);
    rchk("stat", REG_STATUS, 32'h4);
    chk("irq_clr", 1'b0, irq);
    rchk("stat2", REG_STATUS, 32'h0);
  endtask
  task automatic t_cap();
    logic [DW-1:0] v;
    int ln[4] = '{2, SY_LFO, SY_CMP0, SY_CLU};
    for (int s = 0; s < 4; s++) begin
      wreg(8'h0a, 32'h0);
      wreg(8'h08, cw(CLK_SYS, MODE_AR16, 64 + 128 * s));
      tog(ln[s], 1);
      wreg(8'h08, 32'h0);
      rreg(8'h0b, v);
      chk_rng("cap", 1, 12, v);
      rchk("cap_st", REG_STATUS, 32'h4000);
    end
  endtask
  task automatic t_lp();
    logic [DW-1:0] v;
    wreg(8'h11, 32'h0);
    wreg(8'h12, 32'hffff);
    wreg(8'h10, cw(CLK_LFO8, MODE_AR16, 0));
    wreg(8'h0a, 32'h0);
    wreg(8'h08, cw(CLK_SYS, MODE_AR16, 0));
    low_power <= 1'b1;
    cycles(2);
    rreg(8'h0a, v);
    tog(SY_LFO, 8);
    rchk("t2_frozen", 8'h0a, v);
    low_power <= 1'b0;
    chk("wake", 1'b1, woke);
    wreg(8'h08, 32'h0);
    wreg(8'h10, 32'h0);
    rchk("t4_ovf", REG_STATUS, 32'h10);
  endtask
  task automatic t_chain();
    logic [DW-1:0] v;
    wreg(8'h0d, 32'hfffe);
    wreg(8'h0e, 32'hfffe);
    wreg(8'h12, 32'h0);
    wreg(8'h10, 32'h201);
    wreg(8'h0c, cw(CLK_SYS, MODE_AR16, 0));
    cycles(40);
    wreg(8'h0c, 32'h0);
    rreg(8'h12, v);
    chk_rng("chain", 18, 22, v);
  endtask
  // One timer, one burst of clock edges, then its count and the status it raised.
  task automatic t_one(string nm, logic [AW-1:0] b, logic [DW-1:0] c, logic [15:0] r,
      logic [15:0] v0, int ln, int n, logic [15:0] ve, logic [DW-1:0] se);
    wreg(b + 8'h01, 32'(r));
    wreg(b + 8'h02, 32'(v0));
    wreg(b, c);
    tog(ln, n);
    wreg(b, 32'h0);
    rchk(nm, b + 8'h02, 32'(ve));
    rchk({nm, "_st"}, REG_STATUS, se);
  endtask
  task automatic t_modes();
    t_one("t0_13", 8'h00, cw(CLK_PIN, MODE_13BIT, 0), 16'h0000, 16'h001f, 0, 1,
      16'h0100, 32'h0);
    t_one("t0_13w", 8'h00, cw(CLK_PIN, MODE_13BIT, 0), 16'h0000, 16'hff1f, 0, 1,
      16'h0000, 32'h1);
    t_one("t0_8ar", 8'h00, cw(CLK_PIN, MODE_8BIT_AR, 0), 16'h0055, 16'h12ff, 0, 1,
      16'h1255, 32'h1);
    t_one("t0_split", 8'h00, cw(CLK_PIN, MODE_SPLIT, 0), 16'h0000, 16'hffff, 0, 1,
      16'h0000, 32'h41);
    t_one("t2_split", 8'h08, cw(CLK_EXT8, MODE_AR_SPLIT, 0), 16'h3040, 16'h10ff, SY_EXT, 8,
      16'h1140, 32'h4);
    t_one("t2_bad", 8'h08, cw(CLK_DIV4, MODE_AR16, 0), 16'h0000, 16'h0007, SY_EXT, 8,
      16'h0007, 32'h0);
  endtask
  initial begin
    cycles(5);
    rstn <= 1'b1;
    t_map();
    t_pre();
    t_t1();
    t_ovf(32'h0, 1'b0);
    t_ovf(32'h4, 1'b1);
    t_cap();
    t_lp();
    t_modes();
    t_chain();
    end_sim();
  end
endmodule
